// File: verilog/wct_pkg.sv
// constants and types shared by the wetting-current timer block
`default_nettype none
package wct_pkg;
    // ******************************************************************
    // channel counts
    // ******************************************************************
    localparam int NUM_PROG = 8;
    localparam int NUM_GND  = 14;
    localparam int NUM_CH   = NUM_PROG + NUM_GND;
    localparam int CODE_W   = 3;

    // ******************************************************************
    // serial frame layout
    // ******************************************************************
    localparam int         FRAME_BITS      = 32;
    localparam int         ADDR_MSB        = 31;
    localparam int         ADDR_LSB        = 25;
    localparam int         RW_BIT          = 24;
    localparam int         DATA_MSB        = 23;
    localparam int         REPLY_FAULT_BIT = 23;
    localparam int         REPLY_INT_BIT   = 22;
    localparam int         REPLY_DATA_MSB  = 21;
    localparam logic [0:0] RW_WRITE        = 1'h1;
    localparam logic [5:0] FRAME_BITS_CNT  = 6'h20;

    // ******************************************************************
    // register map
    // ******************************************************************
    localparam logic [6:0]  ADDR_CW_PROG  = 7'h0b;
    localparam logic [6:0]  ADDR_CW_GND   = 7'h0c;
    localparam logic [7:0]  CW_PROG_RESET = 8'h00;
    localparam logic [13:0] CW_GND_RESET  = 14'h0000;

    // ******************************************************************
    // current codes
    // ******************************************************************
    localparam logic [2:0] LEVEL_DEFAULT     = 3'h6;
    localparam logic [2:0] SUSTAIN_CODE_GND  = 3'h0;
    localparam logic [2:0] SUSTAIN_CODE_PROG = 3'h0;

    // ******************************************************************
    // timing
    // ******************************************************************
    localparam int CLK_FREQ_HZ   = 125_000_000;
    localparam int WET_TIME_MS   = 20;
    localparam int TICK_TIME_US  = 1000;
    localparam int TICK_CYCLES   = (CLK_FREQ_HZ / 1_000_000) * TICK_TIME_US;
    localparam int WET_TICKS     = (WET_TIME_MS * 1000) / TICK_TIME_US;
    localparam logic [4:0] WET_TICKS_LAST = 5'(WET_TICKS - 1);
    localparam int SYNC_STAGES   = 3;

    typedef enum logic {CH_WETTING, CH_SUSTAIN} wct_ch_state_t;
endpackage
`default_nettype wire

// File: verilog/wct_frame_if.sv
// interface carrying whole serial frames between shifter and register logic
`timescale 1ns/10ps
`default_nettype none
interface wct_frame_if;
    logic        frame_valid;
    logic [31:0] frame_word;
    logic [31:0] reply_word;

    modport shifter (output frame_valid, output frame_word, input reply_word);
    modport core (input frame_valid, input frame_word, output reply_word);
endinterface
`default_nettype wire

// File: verilog/wct_spi_frame.sv
// serial slave: synchronises pins and assembles 32-bit frames
`timescale 1ns/10ps
`default_nettype none
module wct_spi_frame (
    input  wire logic   core_clk,
    input  wire logic   resetn,
    input  wire logic   sclk,
    input  wire logic   cs_n,
    input  wire logic   mosi,
    output var  logic   miso,
    wct_frame_if.shifter frm
);
    // ******************************************************************
    // pin synchronisers
    // ******************************************************************
    logic [2:0] s1_ff, s2_ff, s3_ff;
    logic [2:0] lvl_ff, nxt_lvl;
    logic [2:0] pins;
    assign pins = {cs_n, sclk, mosi};

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s1_ff  <= 3'h4;
            s2_ff  <= 3'h4;
            s3_ff  <= 3'h4;
            lvl_ff <= 3'h4;
        end else begin
            s1_ff  <= pins;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            lvl_ff <= nxt_lvl;
        end
    end

    // a level counts only once the second and third stage agree
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            nxt_lvl[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : lvl_ff[i];
        end
    end

    logic cs_fall, cs_rise, sck_rise, sck_fall, selected;
    assign cs_fall  = lvl_ff[2] & ~nxt_lvl[2];
    assign cs_rise  = ~lvl_ff[2] & nxt_lvl[2];
    assign sck_rise = ~lvl_ff[1] & nxt_lvl[1];
    assign sck_fall = lvl_ff[1] & ~nxt_lvl[1];
    assign selected = ~lvl_ff[2];

    // ******************************************************************
    // shift registers
    // ******************************************************************
    logic [31:0] rx_ff, nxt_rx, tx_ff, nxt_tx;
    logic [5:0]  cnt_ff, nxt_cnt;
    logic        miso_ff, nxt_miso, valid_ff, nxt_valid;

    always_comb begin
        nxt_rx    = rx_ff;
        nxt_tx    = tx_ff;
        nxt_cnt   = cnt_ff;
        nxt_miso  = miso_ff;
        nxt_valid = 1'b0;
        if (cs_fall) begin
            nxt_tx   = frm.reply_word;
            nxt_miso = frm.reply_word[31];
            nxt_cnt  = 6'h00;
        end else if (selected && sck_rise) begin
            nxt_rx = {rx_ff[30:0], nxt_lvl[0]};
            nxt_tx = {tx_ff[30:0], 1'b0};
            if (cnt_ff != 6'h3f) begin
                nxt_cnt = cnt_ff + 6'h01;
            end
        end else if (selected && sck_fall) begin
            nxt_miso = tx_ff[31];
        end else if (cs_rise) begin
            // short or long frames are dropped whole
            nxt_valid = (cnt_ff == wct_pkg::FRAME_BITS_CNT);
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rx_ff    <= 32'h0000_0000;
            tx_ff    <= 32'h0000_0000;
            cnt_ff   <= 6'h00;
            miso_ff  <= 1'b0;
            valid_ff <= 1'b0;
        end else begin
            rx_ff    <= nxt_rx;
            tx_ff    <= nxt_tx;
            cnt_ff   <= nxt_cnt;
            miso_ff  <= nxt_miso;
            valid_ff <= nxt_valid;
        end
    end

    assign miso            = miso_ff;
    assign frm.frame_valid = valid_ff;
    assign frm.frame_word  = rx_ff;
endmodule // wct_spi_frame
`default_nettype wire

// File: verilog/wct_top.sv
// wetting-current timer control: per-channel timers and continuous-wetting registers
//
// Summary of operation
// - every one of the 22 inputs owns its own 20 ms timer
// - a channel timer restarts when that channel's comparator reports a crossing
// - on expiry in pulsed mode the source drops to sustain, 2.0 mA for ground
// - a clear continuous bit means wetting current first, sustain after 20 ms
// - a set continuous bit holds full wetting current with no reduction
// - all continuous bits are zero after reset, so pulsed operation
// - continuous registers accept writes at any time in normal mode
// - programmable register at address 0x0b, bits 7..0 are channels, rest zero
// - ground register at address 0x0c, bits 13..0 are channels, rest zero
// - frame holds address, write bit, data; reply echoes address and write bit, then fault, flag, data
// - each channel has a 3-bit level code, default 110 meaning 16 mA
`timescale 1ns/10ps
`default_nettype none
module wct_top #(
    parameter int TICK_CYCLES = wct_pkg::TICK_CYCLES
) (
    input  wire logic                                      core_clk,
    input  wire logic                                      resetn,
    input  wire logic                                      sclk,
    input  wire logic                                      cs_n,
    input  wire logic                                      mosi,
    output var  logic                                      miso,
    input  wire logic [wct_pkg::NUM_CH-1:0]                cmp_out,
    input  wire logic [wct_pkg::NUM_CH*wct_pkg::CODE_W-1:0] level_code,
    input  wire logic                                      fault_summary,
    input  wire logic                                      interrupt_flag,
    output var  logic [wct_pkg::NUM_CH*wct_pkg::CODE_W-1:0] source_code,
    output var  logic [wct_pkg::NUM_CH-1:0]                sustain_active
);
    localparam int PW = $clog2(TICK_CYCLES);
    localparam logic [PW-1:0] TICK_LAST = PW'(TICK_CYCLES - 1);

    // ******************************************************************
    // frame transport
    // ******************************************************************
    wct_frame_if frm ();

    wct_spi_frame u_spi (
        .core_clk (core_clk),
        .resetn   (resetn),
        .sclk     (sclk),
        .cs_n     (cs_n),
        .mosi     (mosi),
        .miso     (miso),
        .frm      (frm.shifter)
    );

    // ******************************************************************
    // continuous-wetting registers
    // ******************************************************************
    logic [7:0]  cw_prog_ff, nxt_cw_prog;
    logic [13:0] cw_gnd_ff, nxt_cw_gnd;
    logic [31:0] reply_ff, nxt_reply;
    logic [6:0]  f_addr;
    logic        f_write;
    logic [21:0] rd_data;

    assign f_addr  = frm.frame_word[wct_pkg::ADDR_MSB:wct_pkg::ADDR_LSB];
    assign f_write = (frm.frame_word[wct_pkg::RW_BIT] == wct_pkg::RW_WRITE[0]);

    always_comb begin
        nxt_cw_prog = cw_prog_ff;
        nxt_cw_gnd  = cw_gnd_ff;
        nxt_reply   = reply_ff;
        rd_data     = 22'h000000;
        // writes are taken whenever a complete frame arrives
        if (frm.frame_valid && f_write) begin
            if (f_addr == wct_pkg::ADDR_CW_PROG) begin
                nxt_cw_prog = frm.frame_word[7:0];
            end
            if (f_addr == wct_pkg::ADDR_CW_GND) begin
                nxt_cw_gnd = frm.frame_word[13:0];
            end
        end
        if (f_addr == wct_pkg::ADDR_CW_PROG) begin
            rd_data = {14'h0000, nxt_cw_prog};
        end else if (f_addr == wct_pkg::ADDR_CW_GND) begin
            rd_data = {8'h00, nxt_cw_gnd};
        end
        // the answer to a frame goes out during the following frame
        if (frm.frame_valid) begin
            nxt_reply = {frm.frame_word[wct_pkg::ADDR_MSB:wct_pkg::RW_BIT],
                         fault_summary, interrupt_flag, rd_data};
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cw_prog_ff <= wct_pkg::CW_PROG_RESET;
            cw_gnd_ff  <= wct_pkg::CW_GND_RESET;
            reply_ff   <= 32'h0000_0000;
        end else begin
            cw_prog_ff <= nxt_cw_prog;
            cw_gnd_ff  <= nxt_cw_gnd;
            reply_ff   <= nxt_reply;
        end
    end

    assign frm.reply_word = reply_ff;

    // ******************************************************************
    // prescaler
    // ******************************************************************
    logic [PW-1:0] pre_ff, nxt_pre;
    logic          tick_ff, nxt_tick;

    always_comb begin
        nxt_tick = (pre_ff == TICK_LAST);
        nxt_pre  = nxt_tick ? '0 : pre_ff + PW'(1);
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pre_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            pre_ff  <= nxt_pre;
            tick_ff <= nxt_tick;
        end
    end

    // ******************************************************************
    // comparator synchronisers and crossing detect
    // ******************************************************************
    logic [wct_pkg::NUM_CH-1:0] c1_ff, c2_ff, c3_ff, cmp_ff, nxt_cmp, crossing;
    logic [wct_pkg::NUM_CH-1:0] cw_all;

    assign cw_all = {cw_gnd_ff, cw_prog_ff};

    always_comb begin
        nxt_cmp = cmp_ff;
        for (int i = 0; i < wct_pkg::NUM_CH; i++) begin
            if (c2_ff[i] == c3_ff[i]) begin
                nxt_cmp[i] = c3_ff[i];
            end
        end
        crossing = nxt_cmp ^ cmp_ff;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            c1_ff  <= '0;
            c2_ff  <= '0;
            c3_ff  <= '0;
            cmp_ff <= '0;
        end else begin
            c1_ff  <= cmp_out;
            c2_ff  <= c1_ff;
            c3_ff  <= c2_ff;
            cmp_ff <= nxt_cmp;
        end
    end

    // ******************************************************************
    // per-channel wetting timers
    // ******************************************************************
    for (genvar ch = 0; ch < wct_pkg::NUM_CH; ch++) begin : g_ch
        wct_pkg::wct_ch_state_t st_ff, nxt_st;
        logic [4:0]             cnt_ff, nxt_cnt;
        logic [2:0]             code_ff, nxt_code, level, sustain;
        logic                   sus_ff, nxt_sus;

        assign level   = level_code[ch*wct_pkg::CODE_W +: wct_pkg::CODE_W];
        assign sustain = (ch < wct_pkg::NUM_PROG) ? wct_pkg::SUSTAIN_CODE_PROG
                                                  : wct_pkg::SUSTAIN_CODE_GND;

        always_comb begin
            nxt_st  = st_ff;
            nxt_cnt = cnt_ff;
            unique case (st_ff)
                wct_pkg::CH_WETTING: begin
                    if (crossing[ch]) begin
                        nxt_cnt = 5'h00;
                    end else if (tick_ff) begin
                        if (cnt_ff != wct_pkg::WET_TICKS_LAST) begin
                            nxt_cnt = cnt_ff + 5'h01;
                        end else if (!cw_all[ch]) begin
                            nxt_st = wct_pkg::CH_SUSTAIN;
                        end
                    end
                end
                wct_pkg::CH_SUSTAIN: begin
                    if (crossing[ch] || cw_all[ch]) begin
                        nxt_st  = wct_pkg::CH_WETTING;
                        nxt_cnt = 5'h00;
                    end
                end
            endcase
            // continuous mode overrides an expired timer
            nxt_sus  = (nxt_st == wct_pkg::CH_SUSTAIN) && !cw_all[ch];
            nxt_code = nxt_sus ? sustain : level;
        end

        always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
                st_ff   <= wct_pkg::CH_WETTING;
                cnt_ff  <= 5'h00;
                sus_ff  <= 1'b0;
                code_ff <= wct_pkg::LEVEL_DEFAULT;
            end else begin
                st_ff   <= nxt_st;
                cnt_ff  <= nxt_cnt;
                sus_ff  <= nxt_sus;
                code_ff <= nxt_code;
            end
        end

        assign source_code[ch*wct_pkg::CODE_W +: wct_pkg::CODE_W] = code_ff;
        assign sustain_active[ch] = sus_ff;
    end
endmodule // wct_top
`default_nettype wire

// File: verif/wct_monitor.sv
// port-level checks on the wetting-current timer block
`timescale 1ns/10ps
`default_nettype none
module wct_monitor #(
    parameter int TICK_CYCLES = 50
) (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        cs_n,
    input  wire logic        miso,
    input  wire logic [21:0] cmp_out,
    input  wire logic [65:0] level_code,
    input  wire logic [65:0] source_code,
    input  wire logic [21:0] sustain_active
);
    // ****
    // cycles since each raw crossing and since the last frame
    // ****
    int          cyc_ff [22];
    int          csh_ff;
    logic [21:0] cmp_q_ff;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cyc_ff   <= '{default: 0};
            csh_ff   <= 0;
            // cleared like the design's comparator chain, so both see the same first edge
            cmp_q_ff <= '0;
        end else begin
            cmp_q_ff <= cmp_out;
            csh_ff   <= cs_n ? csh_ff + 1 : 0;
            for (int c = 0; c < 22; c++) begin
                cyc_ff[c] <= (cmp_out[c] != cmp_q_ff[c]) ? 0 : cyc_ff[c] + 1;
            end
        end
    end

    // ****
    // properties
    // ****
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    property p_rst;
        disable iff (1'b0) !resetn |-> source_code == {22{3'h6}} && sustain_active == 22'h0
            && miso == 1'b0;
    endproperty
    property p_rel;
        $rose(resetn) |-> (sustain_active == 22'h0) [*8];
    endproperty
    property p_sus_code(int c);
        sustain_active[c] |-> source_code[3*c+:3] == 3'h0;
    endproperty
    property p_wet_code(int c);
        !sustain_active[c] |-> source_code[3*c+:3] == $past(level_code[3*c+:3]);
    endproperty
    property p_sus_min(int c);
        $rose(sustain_active[c]) |-> cyc_ff[c] >= 19 * TICK_CYCLES;
    endproperty
    // a write in the wait may clear a continuous bit late, so no upper bound then
    property p_sus_max(int c);
        $rose(sustain_active[c]) && csh_ff > cyc_ff[c] |-> cyc_ff[c] <= 20 * TICK_CYCLES + 10;
    endproperty
    property p_wake(int c);
        $changed(cmp_out[c]) |-> ##[2:7] !sustain_active[c];
    endproperty
    property p_hold(int c);
        sustain_active[c] && cyc_ff[c] > 8 && csh_ff > 12 |=> sustain_active[c];
    endproperty

    a_rst: assert property (p_rst) else $error("reset values wrong");
    a_rel: assert property (p_rel) else $error("sustain right after reset");
    for (genvar g = 0; g < 22; g++) begin : g_ch
        a_sus_code: assert property (p_sus_code(g)) else $error("sustain code");
        a_wet_code: assert property (p_wet_code(g)) else $error("wetting code");
        a_sus_min: assert property (p_sus_min(g)) else $error("sustain early");
        a_sus_max: assert property (p_sus_max(g)) else $error("sustain late");
        a_wake: assert property (p_wake(g)) else $error("no restart");
        a_hold: assert property (p_hold(g)) else $error("sustain dropped");
    end
    c_sus: cover property ($rose(sustain_active[0]));
    c_wake: cover property ($fell(sustain_active[9]));
    c_frame: cover property ($rose(cs_n));
endmodule // wct_monitor
`default_nettype wire

// File: verif/wct_host.sv
// host-side serial master model for 32-bit register frames
`timescale 1ns/10ps
`default_nettype none
module wct_host (
    input  wire logic        core_clk,
    output var  logic        sclk,
    output var  logic        cs_n,
    output var  logic        mosi,
    input  wire logic        miso,
    output var  logic [31:0] rx,
    output var  logic        rx_v
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b1;
        rx   = 32'h0;
        rx_v = 1'b0;
    end

    // ****
    // mode 0 frame, msb first; clock idles low between frames
    // ****
    // writes go out whenever asked; callers set the 8 and the 14 continuous bits in two separate frames
    // a short frame must be dropped by the device, so it raises no rx_v
    task automatic xfer(input logic [31:0] tx, input int nbits = 32);
        cs_n = 1'b0;
        for (int i = 31; i > 31 - nbits; i--) begin
            mosi = tx[i];
            repeat (8) @(negedge core_clk);
            sclk  = 1'b1;
            rx[i] = miso;
            repeat (8) @(negedge core_clk);
            sclk = 1'b0;
        end
        repeat (8) @(negedge core_clk);
        cs_n = 1'b1;
        mosi = ~mosi;
        rx_v = (nbits == 32);
        @(negedge core_clk);
        rx_v = 1'b0;
        repeat (8) @(negedge core_clk);
    endtask
endmodule // wct_host
`default_nettype wire

// File: verif/test_wct_top.sv
// self-checking bench for the wetting-current timer block
`timescale 1ns/10ps
`default_nettype none
module test_wct_top;
    localparam int TICK = 50;
    logic        core_clk;
    logic        resetn;
    logic        sclk;
    logic        cs_n;
    logic        mosi;
    logic        miso;
    logic        fault_summary;
    logic        interrupt_flag;
    logic        rx_v;
    logic [21:0] cmp_out;
    logic [21:0] sustain_active;
    logic [65:0] level_code;
    logic [65:0] source_code;
    logic [31:0] rx;
    logic [31:0] pend;
    logic [31:0] exp_q[$];
    logic [7:0]  cw_p;
    logic [13:0] cw_g;
    int          err_total;
    int          checks;
    int          cyc;
    int          seed;

    wct_top #(.TICK_CYCLES(TICK)) dut (.core_clk(core_clk), .resetn(resetn), .sclk(sclk),
        .cs_n(cs_n), .mosi(mosi), .miso(miso), .cmp_out(cmp_out), .level_code(level_code),
        .fault_summary(fault_summary), .interrupt_flag(interrupt_flag),
        .source_code(source_code), .sustain_active(sustain_active));
    wct_host host (.core_clk(core_clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
        .rx(rx), .rx_v(rx_v));

    // ****
    // checking helpers
    // ****
    task automatic chk(input logic [65:0] seen, input logic [65:0] want);
        checks++;
        if (seen !== want) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic chk_ch(input logic [21:0] ex);
        logic [65:0] e;
        e = level_code;
        for (int c = 0; c < 22; c++) begin
            if (ex[c]) e[3*c+:3] = 3'h0;
        end
        chk(66'(sustain_active), 66'(ex));
        chk(source_code, e);
    endtask

    // the reply of a frame only shows in the next one, so each frame notes the previous
    task automatic frame(input logic [6:0] a, input logic rw, input logic [23:0] d);
        logic [21:0] v;
        exp_q.push_back(pend);
        {fault_summary, interrupt_flag} = 2'($random(seed));
        if (rw && a == wct_pkg::ADDR_CW_PROG) cw_p = d[7:0];
        if (rw && a == wct_pkg::ADDR_CW_GND) cw_g = d[13:0];
        v = (a == wct_pkg::ADDR_CW_PROG) ? {14'h0, cw_p} :
            (a == wct_pkg::ADDR_CW_GND) ? {8'h0, cw_g} : 22'h0;
        pend = {a, rw, fault_summary, interrupt_flag, v};
        host.xfer({a, rw, d});
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        if (rx_v === 1'b1) begin
            chk(66'(rx), 66'(exp_q.pop_front()));
        end
    end

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_total++;
            results();
        end
    end

    initial begin
        // starts high so the first edge after time zero is a falling one
        core_clk = 1'b1;
        forever #4 core_clk = ~core_clk;
    end

    // ****
    // main sequence
    // ****
    initial begin
        seed = 46110;
        err_total = 0;
        checks = 0;
        cyc = 0;
        resetn = 1'b1;
        cmp_out = 22'h0;
        pend = 32'h0;
        cw_p = 8'h0;
        cw_g = 14'h0;
        fault_summary = 1'b0;
        interrupt_flag = 1'b0;
        level_code = {22{3'h6}};
        // reset falls after time zero so every flop is sure to see the edge
        @(negedge core_clk);
        resetn = 1'b0;
        repeat (10) @(negedge core_clk);
        chk_ch(22'h0);
        resetn = 1'b1;
        repeat (5) @(negedge core_clk);
        frame(wct_pkg::ADDR_CW_PROG, 1'b0, 24'h0);
        frame(wct_pkg::ADDR_CW_GND, 1'b0, 24'h0);
        $display("reset values done");
        frame(wct_pkg::ADDR_CW_PROG, 1'b1, 24'($random(seed)) | 24'hffff00);
        frame(wct_pkg::ADDR_CW_GND, 1'b1, 24'($random(seed)) | 24'hffc000);
        frame(7'h7f, 1'b1, 24'hffffff);
        frame(7'h7f, 1'b0, 24'h0);
        // 31 bits laid out so that a device taking them would write ~cw_p
        host.xfer({wct_pkg::ADDR_CW_PROG[5:0], 1'b1, 16'h0000, ~cw_p, 1'b0}, 31);
        frame(wct_pkg::ADDR_CW_PROG, 1'b0, 24'h0);
        $display("register access done");
        level_code = {$random(seed), $random(seed), 2'($random(seed))};
        cmp_out = ~cmp_out;
        repeat (10) @(negedge core_clk);
        chk_ch(22'h0);
        repeat (18 * TICK) @(negedge core_clk);
        chk_ch(22'h0);
        repeat (2 * TICK + 20) @(negedge core_clk);
        chk_ch(~{cw_g, cw_p});
        cmp_out[0] = ~cmp_out[0];
        cmp_out[9] = ~cmp_out[9];
        repeat (10 * TICK) @(negedge core_clk);
        cmp_out[0] = ~cmp_out[0];
        repeat (12 * TICK) @(negedge core_clk);
        chk_ch(~{cw_g, cw_p} & 22'h3ffffe);
        $display("pulsed timer done");
        frame(wct_pkg::ADDR_CW_PROG, 1'b1, 24'hff);
        frame(wct_pkg::ADDR_CW_GND, 1'b1, 24'h3fff);
        repeat (10) @(negedge core_clk);
        chk_ch(22'h0);
        frame(wct_pkg::ADDR_CW_PROG, 1'b1, 24'h0);
        repeat (TICK + 10) @(negedge core_clk);
        chk_ch(22'h0000ff);
        frame(wct_pkg::ADDR_CW_GND, 1'b0, 24'h0);
        $display("continuous mode done");
        results();
    end
endmodule // test_wct_top

bind wct_top wct_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (.core_clk(core_clk),
    .resetn(resetn), .cs_n(cs_n), .miso(miso), .cmp_out(cmp_out), .level_code(level_code),
    .source_code(source_code), .sustain_active(sustain_active));
`default_nettype wire
